//--- rtl/tcsi_pkg.sv
package tcsi_pkg;

  // pointer codes of the register map
  localparam logic [7:0] TCSI_PTR_HOT      = 8'h00;
  localparam logic [7:0] TCSI_PTR_DELTA    = 8'h01;
  localparam logic [7:0] TCSI_PTR_COLD     = 8'h02;
  localparam logic [7:0] TCSI_PTR_RAW      = 8'h03;
  localparam logic [7:0] TCSI_PTR_LIM_BASE = 8'h10;

  // byte index of the last byte of a register
  localparam logic [1:0] TCSI_LAST_WORD = 2'h1;
  localparam logic [1:0] TCSI_LAST_RAW  = 2'h2;
  localparam logic [1:0] TCSI_LAST_NONE = 2'h0;

  // fixed upper address bits, lower three come from the address-select pins
  localparam logic [3:0] TCSI_ADDR_FIXED = 4'hc;

  localparam int TCSI_NUM_ALERT = 4;
  localparam logic [15:0] TCSI_LIMIT_RST = 16'h0000;
  localparam logic [7:0]  TCSI_PTR_RST   = 8'h00;

  // read clock hold interval, in ns, and its cycle count at 200 MHz (rounded up)
  localparam int TCSI_CLK_PERIOD_PS = 5000;
  localparam int TCSI_HOLD_NS       = 1000;
  localparam int TCSI_HOLD_CYC      = (TCSI_HOLD_NS * 1000 + TCSI_CLK_PERIOD_PS - 1)
                                      / TCSI_CLK_PERIOD_PS;

  // temperature word bundle: hot, delta, cold, raw
  localparam int TCSI_TEMP_W = 16;
  localparam int TCSI_RAW_W  = 24;
  localparam int TCSI_MEAS_W = 3 * TCSI_TEMP_W + TCSI_RAW_W;

endpackage

//--- rtl/tcsi_word_sync.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// toggle handshake carrying one word from the measurement clock to clk_in
module tcsi_word_sync #(
  parameter int W = 72
) (
  // source side
  input  wire logic         src_clk_in,
  input  wire logic         src_rst_in,
  input  wire logic         src_valid_in,
  input  wire logic [W-1:0] src_data_in,
  output logic              src_ready_out,
  // destination side
  input  wire logic         dst_clk_in,
  input  wire logic         dst_rst_in,
  output logic              dst_valid_out,
  output logic [W-1:0]      dst_data_out
);

  logic         busy_q;
  logic         req_q;
  logic [W-1:0] hold_q;
  logic         ack_m_q;
  logic         ack_s_q;
  logic         req_m_q;
  logic         req_s_q;
  logic         req_p_q;
  logic         ack_q;

  if (W < 1) begin : g_chk
    $error("tcsi_word_sync: width must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // source: word held stable until the acknowledge toggle returns
  always_ff @(posedge src_clk_in) begin
    if (src_rst_in) begin
      busy_q <= 1'b0;
      req_q  <= 1'b0;
      hold_q <= '0;
    end else if (!busy_q && src_valid_in) begin
      busy_q <= 1'b1;
      req_q  <= ~req_q;
      hold_q <= src_data_in;
    end else if (busy_q && (ack_s_q == req_q)) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge src_clk_in) begin
    if (src_rst_in) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end else begin
      ack_m_q <= ack_q;
      ack_s_q <= ack_m_q;
    end
  end

  assign src_ready_out = ~busy_q;

  ////////////////////////////////////////////////////////////////////////////////
  // destination: copy once per request toggle
  always_ff @(posedge dst_clk_in) begin
    if (dst_rst_in) begin
      req_m_q       <= 1'b0;
      req_s_q       <= 1'b0;
      req_p_q       <= 1'b0;
      ack_q         <= 1'b0;
      dst_valid_out <= 1'b0;
      dst_data_out  <= '0;
    end else begin
      req_m_q       <= req_q;
      req_s_q       <= req_m_q;
      req_p_q       <= req_s_q;
      dst_valid_out <= req_s_q ^ req_p_q;
      if (req_s_q ^ req_p_q) begin
        dst_data_out <= hold_q;
        ack_q        <= req_s_q;
      end
    end
  end

endmodule // tcsi_word_sync

//--- rtl/tcsi_reader.sv
`timescale 1ns/1ps
// Behaviour
// - sequential read starts at last written pointer
// - acked byte advances internal byte pointer
// - stop condition ends the read
// - writes never step into the next register
// - pointers 0,1,2 select hot, delta, cold
// - words sent upper byte first, two's complement
// - temperature and raw registers ignore writes
// - four alert pins assert beyond their limits
// - eight-bit pointer, write-only, loaded by host
// - ack only matching address, lsb selects read
// - pointer kept between transfers
// - hold clock low after each read ack
// - start or stop mid-byte abandons transfer
module tcsi_reader
  import tcsi_pkg::*;
#(
  parameter int HOLD_CYC = TCSI_HOLD_CYC
) (
  // system
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // measurement domain
  input  wire logic                   meas_clk_in,
  input  wire logic                   meas_rst_in,
  input  wire logic                   meas_valid_in,
  input  wire logic [TCSI_TEMP_W-1:0] hot_in,
  input  wire logic [TCSI_TEMP_W-1:0] delta_in,
  input  wire logic [TCSI_TEMP_W-1:0] cold_in,
  input  wire logic [TCSI_RAW_W-1:0]  raw_in,
  output logic                        meas_ready_out,
  // serial pins, open drain
  input  wire logic [2:0]             addr_sel_in,
  input  wire logic                   scl_in,
  output logic                        scl_out,
  output logic                        scl_oe_out,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_out,
  // alerts
  output logic [TCSI_NUM_ALERT-1:0]   alert_out
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_HOLD, ST_RD_BYTE, ST_RD_ACK
  } tcsi_state_e;

  if (HOLD_CYC < 1 || HOLD_CYC > 65535) begin : g_chk
    $error("tcsi_reader: hold count out of range");
  end

  tcsi_state_e             state_q;
  logic                    scl_m_q, sda_m_q;
  logic [2:0]              adr_m_q;
  logic                    scl_s_q, sda_s_q, scl_p_q, sda_p_q;
  logic [2:0]              adr_s_q;
  logic                    scl_rise, scl_fall, start_det, stop_det;
  logic [3:0]              cnt_q;
  logic [7:0]              sh_q;
  logic [7:0]              tx_q;
  logic                    rnw_q;
  logic                    acked_q;
  logic [1:0]              wcnt_q;
  logic [7:0]              ptr_q;
  logic [7:0]              bptr_q;
  logic [1:0]              bidx_q;
  logic [15:0]             hold_q;
  logic [TCSI_TEMP_W-1:0]  hot_q, delta_q, cold_q;
  logic [TCSI_RAW_W-1:0]   raw_q;
  logic [15:0]             lim_q [TCSI_NUM_ALERT];
  logic                    meas_upd;
  logic [TCSI_MEAS_W-1:0]  meas_word;
  logic [7:0]              rd_now;

  ////////////////////////////////////////////////////////////////////////////////
  // measurement words cross from their own clock
  tcsi_word_sync #(.W(TCSI_MEAS_W)) u_sync (
    .src_clk_in    (meas_clk_in),
    .src_rst_in    (meas_rst_in),
    .src_valid_in  (meas_valid_in),
    .src_data_in   ({hot_in, delta_in, cold_in, raw_in}),
    .src_ready_out (meas_ready_out),
    .dst_clk_in    (clk_in),
    .dst_rst_in    (rst_in),
    .dst_valid_out (meas_upd),
    .dst_data_out  (meas_word)
  );

  // read-only copies, only the measurement path loads them
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hot_q   <= '0;
      delta_q <= '0;
      cold_q  <= '0;
      raw_q   <= '0;
    end else if (meas_upd) begin
      {hot_q, delta_q, cold_q, raw_q} <= meas_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_m_q <= 1'b1;
      sda_m_q <= 1'b1;
      adr_m_q <= 3'h0;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      adr_s_q <= 3'h0;
    end else begin
      scl_m_q <= scl_in;
      sda_m_q <= sda_in;
      adr_m_q <= addr_sel_in;
      scl_s_q <= scl_m_q;
      sda_s_q <= sda_m_q;
      adr_s_q <= adr_m_q;
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  ////////////////////////////////////////////////////////////////////////////////
  // register map helpers
  function automatic logic is_lim(input logic [7:0] p);
    return (p >= TCSI_PTR_LIM_BASE) && (p < TCSI_PTR_LIM_BASE + 8'(TCSI_NUM_ALERT));
  endfunction

  function automatic logic [1:0] last_idx(input logic [7:0] p);
    if (p == TCSI_PTR_RAW) return TCSI_LAST_RAW;
    if (p <= TCSI_PTR_COLD || is_lim(p)) return TCSI_LAST_WORD;
    return TCSI_LAST_NONE;
  endfunction

  // upper byte first for every word
  always_comb begin
    rd_now = 8'h00;
    unique case (bptr_q)
      TCSI_PTR_HOT:   rd_now = bidx_q[0] ? hot_q[7:0]   : hot_q[15:8];
      TCSI_PTR_DELTA: rd_now = bidx_q[0] ? delta_q[7:0] : delta_q[15:8];
      TCSI_PTR_COLD:  rd_now = bidx_q[0] ? cold_q[7:0]  : cold_q[15:8];
      TCSI_PTR_RAW:   rd_now = raw_q[8'(23 - 8 * bidx_q) -: 8];
      default: begin
        if (is_lim(bptr_q)) begin
          rd_now = bidx_q[0] ? lim_q[bptr_q[1:0]][7:0] : lim_q[bptr_q[1:0]][15:8];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial target
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 4'h0;
      sh_q       <= 8'h00;
      tx_q       <= 8'h00;
      rnw_q      <= 1'b0;
      acked_q    <= 1'b0;
      wcnt_q     <= 2'h0;
      ptr_q      <= TCSI_PTR_RST;
      bptr_q     <= TCSI_PTR_RST;
      bidx_q     <= 2'h0;
      hold_q     <= 16'h0000;
      sda_oe_out <= 1'b0;
      scl_oe_out <= 1'b0;
      for (int i = 0; i < TCSI_NUM_ALERT; i++) begin
        lim_q[i] <= TCSI_LIMIT_RST;
      end
    end else if (start_det) begin
      state_q    <= ST_ADDR;
      cnt_q      <= 4'h0;
      sda_oe_out <= 1'b0;
      scl_oe_out <= 1'b0;
    end else if (stop_det) begin
      state_q    <= ST_IDLE;
      sda_oe_out <= 1'b0;
      scl_oe_out <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            if (sh_q[7:1] == {TCSI_ADDR_FIXED, adr_s_q}) begin
              rnw_q      <= sh_q[0];
              sda_oe_out <= 1'b1;
              state_q    <= ST_ADDR_ACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            cnt_q      <= 4'h0;
            wcnt_q     <= 2'h0;
            if (rnw_q) begin
              bptr_q     <= ptr_q;
              bidx_q     <= 2'h0;
              hold_q     <= 16'h0000;
              scl_oe_out <= 1'b1;
              state_q    <= ST_HOLD;
            end else begin
              state_q <= ST_WR_BYTE;
            end
          end
        end
        ST_WR_BYTE: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            sda_oe_out <= 1'b1;
            state_q    <= ST_WR_ACK;
            if (wcnt_q != 2'h3) begin
              wcnt_q <= wcnt_q + 2'h1;
            end
            if (wcnt_q == 2'h0) begin
              ptr_q <= sh_q;
            end else if (is_lim(ptr_q) && wcnt_q == 2'h1) begin
              lim_q[ptr_q[1:0]][15:8] <= sh_q;
            end else if (is_lim(ptr_q) && wcnt_q == 2'h2) begin
              lim_q[ptr_q[1:0]][7:0] <= sh_q;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            cnt_q      <= 4'h0;
            state_q    <= ST_WR_BYTE;
          end
        end
        ST_HOLD: begin
          hold_q <= hold_q + 16'h0001;
          if (hold_q == 16'(HOLD_CYC - 1)) begin
            scl_oe_out <= 1'b0;
            sda_oe_out <= ~rd_now[7];
            tx_q       <= {rd_now[6:0], 1'b0};
            cnt_q      <= 4'h1;
            state_q    <= ST_RD_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              sda_oe_out <= 1'b0;
              state_q    <= ST_RD_ACK;
            end else begin
              sda_oe_out <= ~tx_q[7];
              tx_q       <= {tx_q[6:0], 1'b0};
              cnt_q      <= cnt_q + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            acked_q <= ~sda_s_q;
          end else if (scl_fall) begin
            if (acked_q) begin
              if (bidx_q == last_idx(bptr_q)) begin
                bptr_q <= bptr_q + 8'h01;
                bidx_q <= 2'h0;
              end else begin
                bidx_q <= bidx_q + 2'h1;
              end
              hold_q     <= 16'h0000;
              scl_oe_out <= 1'b1;
              state_q    <= ST_HOLD;
            end else begin
              state_q <= ST_IDLE; // nak: leave data line released for the stop
            end
          end
        end
      endcase
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // alert channels compare the hot junction against each limit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      alert_out <= '0;
    end else begin
      for (int i = 0; i < TCSI_NUM_ALERT; i++) begin
        alert_out[i] <= $signed(hot_q) > $signed(lim_q[i]);
      end
    end
  end

endmodule // tcsi_reader

//--- verif/tcsi_host_model.sv
`timescale 1ns/1ps
module tcsi_host_model (
  // clock
  input  wire logic clk_in,
  // bus wire levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // host drive, 1 releases the line
  output logic      scl_out,
  output logic      sda_out,
  output logic      stuck_out
);
  localparam int HALF = 30; // keeps each scl phase above 20 clk_in
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    stuck_out = 1'b0;
  end
  task automatic gap();
    repeat (HALF) @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic start();
    sda_out = 1'b1;
    gap();
    scl_out = 1'b1;
    gap();
    sda_out = 1'b0;
    gap();
    scl_out = 1'b0;
    gap();
  endtask
  task automatic stop();
    sda_out = 1'b0;
    gap();
    scl_out = 1'b1;
    gap();
    sda_out = 1'b1;
    gap();
  endtask
  // waits out the target's clock hold, bounded so a stuck line ends the run
  task automatic bit_io(input logic b, output logic s);
    int n;
    n = 0;
    sda_out = b;
    gap();
    scl_out = 1'b1;
    while (scl_in !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    stuck_out = (n >= 400);
    gap();
    s = sda_in;
    scl_out = 1'b0;
    gap();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack, a);
  endtask
endmodule // tcsi_host_model

//--- verif/tcsi_reader_assertions.sv
`timescale 1ns/1ps
module tcsi_reader_assertions
  import tcsi_pkg::*;
#(
  parameter int HOLD_CYC = TCSI_HOLD_CYC
) (
  // system
  input wire logic                      clk_in,
  input wire logic                      rst_in,
  // measurement side
  input wire logic                      meas_clk_in,
  input wire logic                      meas_rst_in,
  input wire logic                      meas_valid_in,
  input wire logic                      meas_ready_out,
  // serial pins
  input wire logic                      scl_in,
  input wire logic                      sda_in,
  input wire logic                      scl_out,
  input wire logic                      scl_oe_out,
  input wire logic                      sda_out,
  input wire logic                      sda_oe_out,
  input wire logic [TCSI_NUM_ALERT-1:0] alert_out
);
  logic [15:0] hold_cnt_q;
  logic [15:0] hold_cnt_d;
  always_comb hold_cnt_d = scl_oe_out ? hold_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_in) begin
    if (rst_in) hold_cnt_q <= 16'h0000;
    else hold_cnt_q <= hold_cnt_d;
  end
  sequence s_hold_start;
    $rose(scl_oe_out);
  endsequence
  sequence s_hold_end;
    $fell(scl_oe_out);
  endsequence
  // data rising while the clock stays high
  sequence s_stop_seen;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  open_drain_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !scl_out && !sda_out) else $error("bus driven to high level");
  hold_len_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s_hold_end |-> hold_cnt_q == 16'(HOLD_CYC)) else $error("clock hold length wrong");
  hold_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
    scl_oe_out |-> hold_cnt_q < 16'(HOLD_CYC)) else $error("clock hold overran");
  hold_after_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s_hold_start |-> !$past(scl_in)) else $error("clock hold began with scl high");
  data_edge_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(sda_oe_out) && !$fell(scl_oe_out) |-> !scl_in) else $error("sda pulled in scl high");
  hold_data_a: assert property (@(posedge clk_in) disable iff (rst_in)
    scl_oe_out && $past(scl_oe_out) && $past(scl_oe_out, 2) |-> $stable(sda_oe_out))
    else $error("sda moved during clock hold");
  reset_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> !scl_oe_out && !sda_oe_out && alert_out == '0)
    else $error("outputs active after reset");
  meas_take_a: assert property (@(posedge meas_clk_in) disable iff (meas_rst_in)
    meas_valid_in && meas_ready_out |=> !meas_ready_out) else $error("ready stayed after take");
  // two sync stages plus the edge stage before the target sees the stop
  stop_release_a: assert property (@(posedge clk_in) disable iff (rst_in)
    s_stop_seen |-> ##4 (!sda_oe_out && !scl_oe_out)) else $error("lines held after stop");
endmodule // tcsi_reader_assertions

bind tcsi_reader tcsi_reader_assertions #(.HOLD_CYC(HOLD_CYC)) chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .meas_clk_in(meas_clk_in), .meas_rst_in(meas_rst_in),
  .meas_valid_in(meas_valid_in), .meas_ready_out(meas_ready_out), .scl_in(scl_in),
  .sda_in(sda_in),
  .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .alert_out(alert_out));

//--- verif/test_tcsi_reader.sv
`timescale 1ns/1ps
module test_tcsi_reader
  import tcsi_pkg::*;
;
  localparam int HOLD = 4; // short clock hold keeps the run brief
  logic                      clk_in = 1'b0;
  logic                      meas_clk = 1'b0;
  logic                      rst_in = 1'b1;
  logic                      meas_rst = 1'b1;
  logic                      meas_valid = 1'b0;
  logic [TCSI_TEMP_W-1:0]    hot = '0;
  logic [TCSI_TEMP_W-1:0]    delta = '0;
  logic [TCSI_TEMP_W-1:0]    cold = '0;
  logic [TCSI_RAW_W-1:0]     raw = '0;
  logic [2:0]                addr_sel = '0;
  logic                      meas_ready, scl_oe, sda_oe, host_scl, host_sda, stuck;
  logic [TCSI_NUM_ALERT-1:0] alert;
  wire                       scl_w = host_scl & ~scl_oe;
  wire                       sda_w = host_sda & ~sda_oe;
  integer                    seed = 32'hf9cc5930;
  int                        num_errors = 0;
  int                        checks_done = 0;
  int                        p;
  logic [7:0]                q;
  logic                      a;
  logic [7:0]                walk [10];
  always #2.5 clk_in = ~clk_in;
  always #32 meas_clk = ~meas_clk;

  tcsi_reader #(.HOLD_CYC(HOLD)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .meas_clk_in(meas_clk), .meas_rst_in(meas_rst),
    .meas_valid_in(meas_valid), .hot_in(hot), .delta_in(delta), .cold_in(cold), .raw_in(raw),
    .meas_ready_out(meas_ready), .addr_sel_in(addr_sel), .scl_in(scl_w), .scl_out(),
    .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe), .alert_out(alert));
  tcsi_host_model host_u (.clk_in(clk_in), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(host_scl), .sda_out(host_sda), .stuck_out(stuck));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic give_up(input string what);
    num_errors++;
    $display("ERROR %s expected progress seen none", what);
    report_and_stop();
  endtask
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic gt(input logic [15:0] x, input logic [15:0] y);
    return $signed(x) > $signed(y);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic send_meas(input logic corner);
    int n;
    n = 0;
    @(negedge meas_clk);
    hot = corner ? 16'h8000 : 16'($random(seed));
    delta = corner ? 16'hffff : 16'($random(seed));
    cold = corner ? 16'h7fff : 16'($random(seed));
    raw = corner ? 24'hfc0001 : 24'($random(seed));
    meas_valid = 1'b1;
    while (meas_ready !== 1'b1 && n < 50) begin
      @(negedge meas_clk);
      n++;
    end
    if (n >= 50) give_up("meas take");
    @(negedge meas_clk);
    meas_valid = 1'b0;
    while (meas_ready !== 1'b1 && n < 100) begin
      @(negedge meas_clk);
      n++;
    end
    if (n >= 100) give_up("meas ready");
    repeat (20) @(negedge clk_in);
    walk = '{hot[15:8], hot[7:0], delta[15:8], delta[7:0], cold[15:8], cold[7:0],
             raw[23:16], raw[15:8], raw[7:0], 8'h00};
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [23:0] d, input int n);
    host_u.start();
    host_u.xfer({TCSI_ADDR_FIXED, addr_sel, 1'b0}, 1'b1, q, a);
    cmp("write address ack", 24'h0, {23'h0, a});
    host_u.xfer(ptr, 1'b1, q, a);
    for (int i = n - 1; i >= 0; i--) begin
      host_u.xfer(d[8*i +: 8], 1'b1, q, a);
    end
    host_u.stop();
  endtask
  task automatic read_n(input int n, input int off);
    host_u.start();
    host_u.xfer({TCSI_ADDR_FIXED, addr_sel, 1'b1}, 1'b1, q, a);
    cmp("read address ack", 24'h0, {23'h0, a});
    for (int i = 0; i < n; i++) begin
      host_u.xfer(8'hff, 1'(i == n - 1), q, a);
      cmp("read byte", {16'h0, walk[off + i]}, {16'h0, q});
    end
    host_u.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge stuck) give_up("scl release");
  initial begin
    repeat (100000) @(posedge clk_in);
    give_up("run length");
  end
  initial begin
    addr_sel = 3'($random(seed));
    repeat (12) @(negedge clk_in);
    repeat (2) @(negedge meas_clk);
    @(negedge clk_in);
    rst_in = 1'b0;
    meas_rst = 1'b0;
    repeat (4) @(negedge clk_in);
    for (int it = 0; it < 2; it++) begin
      send_meas(it == 0);
      p = (it == 0) ? 0 : ($random(seed) & 3);
      wr(8'(p), 24'h0, 0);
      read_n(10 - 2 * p, 2 * p);
      read_n(2, 2 * p);
      $display("test walk %0d done", it);
    end
    host_u.start();
    host_u.xfer({TCSI_ADDR_FIXED, addr_sel, 1'b0}, 1'b1, q, a);
    for (int i = 0; i < 4; i++) begin
      host_u.bit_io(1'b1, a);
    end
    host_u.stop();
    cmp("lines released", 24'h0, {22'h0, scl_oe, sda_oe});
    read_n(2, 2 * p);
    $display("test abort done");
    wr(8'h00, 24'h5aa53c, 3);
    read_n(2, 0);
    wr(8'h02, 24'h00a5c3, 2);
    read_n(2, 4);
    $display("test read only done");
    host_u.start();
    host_u.xfer({TCSI_ADDR_FIXED, ~addr_sel, 1'b1}, 1'b1, q, a);
    cmp("foreign address ack", 24'h1, {23'h0, a});
    host_u.stop();
    $display("test address done");
    // extra third byte must not reach the next limit
    wr(8'h10, {hot - 16'h0001, 8'h7f}, 3);
    wr(8'h13, {8'h00, hot}, 2);
    repeat (20) @(negedge clk_in);
    cmp("alerts", {20'h0, gt(hot, hot), gt(hot, 16'h0), gt(hot, 16'h0),
        gt(hot, hot - 16'h0001)}, {20'h0, alert});
    // second limit must still read its reset value
    walk[0] = 8'h00;
    walk[1] = 8'h00;
    wr(8'h11, 24'h0, 0);
    read_n(2, 0);
    $display("test alert done");
    report_and_stop();
  end
endmodule // test_tcsi_reader
